// ==== conveyor_status_input_words.sv ====
// Overview of operation
// - forward discharge loads both forward tracking words with that carton's data
// - reverse discharge loads both reverse tracking words with that carton's data
// - tracking words update only on discharge to conveyor outside own network
// - port word bits 0-3 pin 3, bits 4-7 pin 4 of four ports
// - sensor bits read 1 blocked, 0 clear, inverting raw pin as needed
// - polarity inversion latched from auto-configuration, applied to later reads
// - port and stop words read-only; writes ignored
// - stop bit 5 set while stop active in same stop group
// - stop bit 6 set while stop due to lost communication connection
// - stop bit 7 set while stop due to lost PLC connection
// - stop bit 8 set while stop asserted on left control port
// - stop bit 9 set while stop asserted on right control port
// - stop bit 10 set while stop commanded by PLC
// - stop bits 0-4 and 11-15 reserved, read zero
// - each tracking value is two independent 16-bit words
`timescale 1ns/1ps
`include "conveyor_status_params.svh"

module conveyor_status_input_words #(
    parameter int unsigned HB_HALF_CYCLES = `HB_HALF_CYCLES
) (
    input wire logic mclk_in,
    input wire logic nrst_in,
    // raw port pins: 0 left sensor, 1 left control, 2 right sensor, 3 right
    input wire conveyor_status_pkg::port_nibble_t pin3_raw_in,
    input wire conveyor_status_pkg::port_nibble_t pin4_raw_in,
    // auto-configuration result: per sensor pin, 1 means invert
    input wire logic autocfg_done_in,
    input wire logic [3:0] autocfg_invert_in,
    // carton discharge event from the downstream zone
    input wire logic discharge_in,
    input wire logic discharge_foreign_in,
    input wire logic dir_reverse_in,
    input wire conveyor_status_pkg::word_t carton_track_w1_in,
    input wire conveyor_status_pkg::word_t carton_track_w2_in,
    // active stop causes, levels
    input wire logic stop_group_in,
    input wire logic stop_comm_lost_in,
    input wire logic stop_plc_lost_in,
    input wire logic stop_left_port_in,
    input wire logic stop_right_port_in,
    input wire logic stop_plc_cmd_in,
    // word access port from the network side
    input wire logic rd_en_in,
    input wire logic wr_en_in,
    input wire conveyor_status_pkg::word_addr_t addr_in,
    input wire conveyor_status_pkg::word_t wdata_in,
    output logic rvalid_out,
    output conveyor_status_pkg::word_t rdata_out,
    output logic wr_refused_out
);
    import conveyor_status_pkg::*;

    // the two pins of each sensor port, ordered as autocfg_invert_in
    // bit 0 left pin 3, 1 right pin 3, 2 left pin 4, 3 right pin 4

    heartbeat_if hb_link ();

    // the 4 s period (2 s half period) far exceeds simulation reach, so it is a parameter
    heartbeat_gen #(
        .HALF_CYCLES(HB_HALF_CYCLES)
    ) u_heartbeat (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .hb(hb_link.src)
    );

    // ---------------- sensor polarity ----------------
    logic [3:0] invert;
    logic [3:0] next_invert;
    logic cfg_seen;
    logic next_cfg_seen;

    // only the first configuration pass sets polarity; later passes
    // are ignored so readings never flip mid-run
    always_comb begin
        next_invert = invert;
        next_cfg_seen = cfg_seen;
        if (autocfg_done_in && !cfg_seen) begin
            next_invert = autocfg_invert_in;
            next_cfg_seen = 1'b1;
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            invert <= `INVERT_RESET;
            cfg_seen <= 1'b0;
        end else begin
            invert <= next_invert;
            cfg_seen <= next_cfg_seen;
        end
    end

    // ---------------- port input word ----------------
    word_t port_word;
    word_t next_port_word;
    port_nibble_t pin3_norm;
    port_nibble_t pin4_norm;

    // sensor pins normalised to 1 = blocked; control pins pass raw
    always_comb begin
        pin3_norm = pin3_raw_in;
        pin4_norm = pin4_raw_in;
        pin3_norm[0] = pin3_raw_in[0] ^ invert[0];
        pin3_norm[2] = pin3_raw_in[2] ^ invert[1];
        pin4_norm[0] = pin4_raw_in[0] ^ invert[2];
        pin4_norm[2] = pin4_raw_in[2] ^ invert[3];
        next_port_word = `WORD_RESET;
        next_port_word[`PIN3_LSB +: 4] = pin3_norm;
        next_port_word[`PIN4_LSB +: 4] = pin4_norm;
        next_port_word[`HEARTBEAT_BIT] = hb_link.beat;
    end

    // sampled every cycle; pins are taken as synchronous
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            port_word <= `WORD_RESET;
        end else begin
            port_word <= next_port_word;
        end
    end

    // ---------------- stop cause word ----------------
    word_t stop_word;
    word_t next_stop_word;

    // each bit follows its cause level; unlisted bits stay zero
    always_comb begin
        next_stop_word = `WORD_RESET;
        next_stop_word[`STOP_GROUP_BIT] = stop_group_in;
        next_stop_word[`STOP_COMM_BIT] = stop_comm_lost_in;
        next_stop_word[`STOP_PLC_LOST_BIT] = stop_plc_lost_in;
        next_stop_word[`STOP_LEFT_BIT] = stop_left_port_in;
        next_stop_word[`STOP_RIGHT_BIT] = stop_right_port_in;
        next_stop_word[`STOP_CMD_BIT] = stop_plc_cmd_in;
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stop_word <= `WORD_RESET;
        end else begin
            stop_word <= next_stop_word;
        end
    end

    // ---------------- tracking capture ----------------
    track_pair_t fwd_track;
    track_pair_t rev_track;
    track_pair_t next_fwd_track;
    track_pair_t next_rev_track;
    logic capture;

    // hand-offs inside the own network carry tracking along the
    // network, so only a foreign discharge is captured
    assign capture = discharge_in && discharge_foreign_in;

    // both words latch in the same edge so a reader never sees a
    // half-updated pair; otherwise the pair holds
    always_comb begin
        next_fwd_track = fwd_track;
        next_rev_track = rev_track;
        if (capture && !dir_reverse_in) begin
            next_fwd_track.w1 = carton_track_w1_in;
            next_fwd_track.w2 = carton_track_w2_in;
        end
        if (capture && dir_reverse_in) begin
            next_rev_track.w1 = carton_track_w1_in;
            next_rev_track.w2 = carton_track_w2_in;
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            fwd_track <= {`WORD_RESET, `WORD_RESET};
            rev_track <= {`WORD_RESET, `WORD_RESET};
        end else begin
            fwd_track <= next_fwd_track;
            rev_track <= next_rev_track;
        end
    end

    // ---------------- word access port ----------------
    word_t next_rdata;
    logic next_rvalid;
    logic next_wr_refused;
    logic addr_mapped;

    // read answer one cycle after the strobe; unmapped reads give zero
    always_comb begin
        next_rvalid = rd_en_in;
        next_rdata = `WORD_RESET;
        addr_mapped = 1'b1;
        case (addr_in)
            `OFS_STOP_CAUSE: next_rdata = stop_word;
            `OFS_PORT_PINS: next_rdata = port_word;
            `OFS_REV_TRACK_W1: next_rdata = rev_track.w1;
            `OFS_REV_TRACK_W2: next_rdata = rev_track.w2;
            `OFS_FWD_TRACK_W1: next_rdata = fwd_track.w1;
            `OFS_FWD_TRACK_W2: next_rdata = fwd_track.w2;
            default: addr_mapped = 1'b0;
        endcase
        if (!rd_en_in) begin
            next_rdata = rdata_out;
        end
        // every word here is read-only: a write changes nothing and
        // is only flagged so the sender can see it was refused
        next_wr_refused = wr_en_in && addr_mapped && (wdata_in == wdata_in);
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rvalid_out <= 1'b0;
            rdata_out <= `WORD_RESET;
            wr_refused_out <= 1'b0;
        end else begin
            rvalid_out <= next_rvalid;
            rdata_out <= next_rdata;
            wr_refused_out <= next_wr_refused;
        end
    end

endmodule : conveyor_status_input_words

// ==== conveyor_status_params.svh ====
`ifndef CONVEYOR_STATUS_PARAMS_SVH
`define CONVEYOR_STATUS_PARAMS_SVH

// word offsets of the read-only status words
`define OFS_STOP_CAUSE 8'h13
`define OFS_PORT_PINS 8'h23
`define OFS_REV_TRACK_W1 8'h79
`define OFS_REV_TRACK_W2 8'h7a
`define OFS_FWD_TRACK_W1 8'hc9
`define OFS_FWD_TRACK_W2 8'hca

// port input word layout
`define PIN3_LSB 0
`define PIN4_LSB 4
`define HEARTBEAT_BIT 15

// stop cause word layout
`define STOP_GROUP_BIT 5
`define STOP_COMM_BIT 6
`define STOP_PLC_LOST_BIT 7
`define STOP_LEFT_BIT 8
`define STOP_RIGHT_BIT 9
`define STOP_CMD_BIT 10

// reset values
`define WORD_RESET 16'h0000
`define INVERT_RESET 4'h0

// heartbeat timing: half period in seconds, clock in hertz
`define HB_HALF_S 2
`define CLK_HZ 200000000
`define HB_HALF_CYCLES (`HB_HALF_S * `CLK_HZ)

`endif

// ==== conveyor_status_pkg.sv ====
package conveyor_status_pkg;

    typedef logic [15:0] word_t;

    // one carton's tracking value as two independent words
    typedef struct packed {
        word_t w2;
        word_t w1;
    } track_pair_t;

    // per-port nibble: left sensor, left control, right sensor, right ctrl
    typedef logic [3:0] port_nibble_t;

    typedef logic [7:0] word_addr_t;

endpackage : conveyor_status_pkg

// ==== conveyor_status_props.sv ====
`timescale 1ns/1ps
module conveyor_status_props #(
    parameter int unsigned HB_HALF_CYCLES = 8
) (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic [3:0] pin3_raw_in,
    input wire logic discharge_in,
    input wire logic discharge_foreign_in,
    input wire logic dir_reverse_in,
    input wire logic [15:0] carton_track_w1_in,
    input wire logic stop_group_in,
    input wire logic stop_comm_lost_in,
    input wire logic stop_plc_lost_in,
    input wire logic stop_left_port_in,
    input wire logic stop_right_port_in,
    input wire logic stop_plc_cmd_in,
    input wire logic rd_en_in,
    input wire logic wr_en_in,
    input wire logic [7:0] addr_in,
    input wire logic rvalid_out,
    input wire logic [15:0] rdata_out,
    input wire logic wr_refused_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    // stop causes in word order, bit 5 upward
    wire [5:0] stops = {stop_plc_cmd_in, stop_right_port_in,
        stop_left_port_in, stop_plc_lost_in, stop_comm_lost_in, stop_group_in};
    sequence rd_at(logic [7:0] a);
        rd_en_in && addr_in == a;
    endsequence
    sequence cap(logic r);
        discharge_in && discharge_foreign_in && dir_reverse_in == r;
    endsequence
    // words lag their inputs one edge, reads answer one edge later
    AST_READ_ANSWER: assert property (rd_en_in |=> rvalid_out)
        else $error("read not answered");
    AST_NO_SPURIOUS: assert property (!rd_en_in |=> !rvalid_out)
        else $error("valid without read");
    AST_WR_REFUSED: assert property (
        wr_en_in && addr_in == 8'h13 |=> wr_refused_out)
        else $error("write not refused");
    AST_STOP_WORD: assert property (
        rd_at(8'h13) |=> rdata_out == {5'h00, $past(stops, 2), 5'h00})
        else $error("stop word wrong");
    AST_PORT_CTRL: assert property (
        rd_at(8'h23) |=> rdata_out[3] == $past(pin3_raw_in[3], 2)
        && rdata_out[1] == $past(pin3_raw_in[1], 2))
        else $error("control pin bits wrong");
    AST_PORT_RSVD: assert property (
        rd_at(8'h23) |=> rdata_out[14:8] == 7'h00)
        else $error("reserved port bits set");
    // one quiet cycle between capture and read keeps the pair unchanged
    AST_FWD_W1: assert property (
        cap(1'b0) ##1 !discharge_in ##1 rd_at(8'hc9)
        |=> rdata_out == $past(carton_track_w1_in, 3))
        else $error("forward word wrong");
    AST_REV_W1: assert property (
        cap(1'b1) ##1 !discharge_in ##1 rd_at(8'h79)
        |=> rdata_out == $past(carton_track_w1_in, 3))
        else $error("reverse word wrong");
endmodule : conveyor_status_props

bind conveyor_status_input_words conveyor_status_props #(
    .HB_HALF_CYCLES(HB_HALF_CYCLES)
) props (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .pin3_raw_in(pin3_raw_in),
    .discharge_in(discharge_in), .discharge_foreign_in(discharge_foreign_in),
    .dir_reverse_in(dir_reverse_in), .carton_track_w1_in(carton_track_w1_in),
    .stop_group_in(stop_group_in), .stop_comm_lost_in(stop_comm_lost_in),
    .stop_plc_lost_in(stop_plc_lost_in), .stop_plc_cmd_in(stop_plc_cmd_in),
    .stop_left_port_in(stop_left_port_in),
    .stop_right_port_in(stop_right_port_in), .rd_en_in(rd_en_in),
    .wr_en_in(wr_en_in), .addr_in(addr_in), .rvalid_out(rvalid_out),
    .rdata_out(rdata_out), .wr_refused_out(wr_refused_out)
);

// ==== heartbeat_gen.sv ====
`timescale 1ns/1ps

module heartbeat_gen #(
    parameter int unsigned HALF_CYCLES = 400000000
) (
    input wire logic mclk_in,
    input wire logic nrst_in,
    heartbeat_if.src hb
);
    import conveyor_status_pkg::*;

    localparam int unsigned HALF_LAST = (HALF_CYCLES > 1) ?
        HALF_CYCLES - 1 : 0;

    logic [28:0] count;
    logic [28:0] next_count;
    logic level;
    logic next_level;

    // half-period counter; level flips when it wraps
    always_comb begin
        next_count = count + 29'h1;
        next_level = level;
        if (count >= HALF_LAST[28:0]) begin
            next_count = 29'h0;
            next_level = ~level;
        end
    end

    // starts high so the first half is the high phase
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count <= 29'h0;
            level <= 1'b1;
        end else begin
            count <= next_count;
            level <= next_level;
        end
    end

    assign hb.beat = level;

endmodule : heartbeat_gen

// ==== heartbeat_if.sv ====
`timescale 1ns/1ps

// carries the heartbeat level from the divider to the status word
interface heartbeat_if;
    logic beat;
    modport src (output beat);
    modport snk (input beat);
endinterface : heartbeat_if

// ==== plc_model.sv ====
`timescale 1ns/1ps
module plc_model (
    input wire logic mclk_in,
    output logic rd_en_out,
    output logic wr_en_out,
    output logic [7:0] addr_out,
    output logic [15:0] wdata_out,
    input wire logic rvalid_in,
    input wire logic [15:0] rdata_in,
    input wire logic refused_in
);
    // idle address shows the inverse, never a stale match
    initial begin
        rd_en_out = 1'b0;
        wr_en_out = 1'b0;
        addr_out = 8'hff;
        wdata_out = 16'h0000;
    end
    // answer is fixed at one cycle, so a late one reads as unknown
    task automatic rd_word(input logic [7:0] a, output logic [15:0] d);
        @(posedge mclk_in);
        rd_en_out <= 1'b1;
        addr_out <= a;
        @(posedge mclk_in);
        rd_en_out <= 1'b0;
        addr_out <= ~a;
        @(negedge mclk_in);
        d = (rvalid_in === 1'b1) ? rdata_in : 16'hxxxx;
    endtask : rd_word
    task automatic wr_word(input logic [7:0] a, output logic r);
        @(posedge mclk_in);
        wr_en_out <= 1'b1;
        addr_out <= a;
        wdata_out <= 16'($urandom);
        @(posedge mclk_in);
        wr_en_out <= 1'b0;
        addr_out <= ~a;
        @(negedge mclk_in);
        r = refused_in;
    endtask : wr_word
endmodule : plc_model

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import conveyor_status_pkg::*;
    localparam int unsigned HB = 8;
    logic mclk_in = 1'b0;
    logic nrst_in = 1'b0;
    port_nibble_t pin3 = 4'h0, pin4 = 4'h0;
    logic cfg_done = 1'b0, dis = 1'b0, foreign = 1'b0, rev = 1'b0;
    logic [3:0] cfg_inv = 4'h0, inv;
    logic [5:0] stops = 6'h00;
    word_t w1 = 16'h0000, w2 = 16'h0000, wdata, rdata, got;
    word_t exp_trk [4] = '{default: 16'h0000};
    word_addr_t addr, tw [4] = '{8'hc9, 8'hca, 8'h79, 8'h7a};
    logic rd_en, wr_en, rvalid, refused, r, last;
    int failures = 0, cmp_count = 0, cycles = 0, run, edges;
    always #2.5 mclk_in = ~mclk_in;
    conveyor_status_input_words #(.HB_HALF_CYCLES(HB)) DUT (
        .mclk_in(mclk_in), .nrst_in(nrst_in), .pin3_raw_in(pin3),
        .pin4_raw_in(pin4), .autocfg_done_in(cfg_done),
        .autocfg_invert_in(cfg_inv), .discharge_in(dis),
        .discharge_foreign_in(foreign), .dir_reverse_in(rev),
        .carton_track_w1_in(w1), .carton_track_w2_in(w2),
        .stop_group_in(stops[0]), .stop_comm_lost_in(stops[1]),
        .stop_plc_lost_in(stops[2]), .stop_left_port_in(stops[3]),
        .stop_right_port_in(stops[4]), .stop_plc_cmd_in(stops[5]),
        .rd_en_in(rd_en), .wr_en_in(wr_en), .addr_in(addr), .wdata_in(wdata),
        .rvalid_out(rvalid), .rdata_out(rdata), .wr_refused_out(refused));
    plc_model plc (.mclk_in(mclk_in), .rd_en_out(rd_en), .wr_en_out(wr_en),
        .addr_out(addr), .wdata_out(wdata), .rvalid_in(rvalid),
        .rdata_in(rdata), .refused_in(refused));
    task automatic chk(input string n, input word_t e, input word_t g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // sensors follow the latched polarity, control pins pass straight
    function automatic word_t exp_port(port_nibble_t a, port_nibble_t b,
        logic [3:0] v);
        return {8'h00, b ^ {1'b0, v[3], 1'b0, v[2]},
            a ^ {1'b0, v[1], 1'b0, v[0]}};
    endfunction : exp_port
    task automatic discharge(input logic d, input logic f);
        @(posedge mclk_in);
        dis <= 1'b1;
        foreign <= f;
        rev <= d;
        w1 <= 16'($urandom);
        w2 <= 16'($urandom);
        @(posedge mclk_in);
        dis <= 1'b0;
        if (f) begin
            exp_trk[{d, 1'b0}] = w1;
            exp_trk[{d, 1'b1}] = w2;
        end
    endtask : discharge
    task automatic finish_test;
        $display("compares %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    // hang guard, well above the few hundred cycles the run needs
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            finish_test();
        end
    end
    initial begin
        void'($urandom(50596));
        repeat (6) @(posedge mclk_in);
        nrst_in <= 1'b1;
        // first config pass sets polarity, the second must be ignored
        inv = 4'($urandom) | 4'h1;
        @(posedge mclk_in);
        cfg_done <= 1'b1;
        cfg_inv <= inv;
        @(posedge mclk_in);
        cfg_inv <= ~inv;
        @(posedge mclk_in);
        cfg_done <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            @(posedge mclk_in);
            pin3 <= (i == 0) ? 4'hf : 4'($urandom);
            pin4 <= (i == 0) ? 4'h0 : 4'($urandom);
            repeat (2) @(posedge mclk_in);
            plc.rd_word(8'h23, got);
            chk("port word", exp_port(pin3, pin4, inv), got & 16'h7fff);
        end
        // reads every two cycles, so a half period spans HB/2 reads
        plc.rd_word(8'h23, got);
        last = got[15];
        run = 0;
        edges = 0;
        repeat (24) begin
            plc.rd_word(8'h23, got);
            run++;
            if (got[15] !== last) begin
                if (edges > 0) chk("heartbeat run", 16'(HB / 2), 16'(run));
                edges++;
                run = 0;
                last = got[15];
            end
        end
        chk("heartbeat edges", 16'h0001, 16'(edges >= 2));
        for (int i = 0; i < 14; i++) begin
            @(posedge mclk_in);
            stops <= (i < 6) ? 6'(1 << i) : 6'($urandom);
            repeat (2) @(posedge mclk_in);
            plc.wr_word(8'h13, r);
            chk("write refused", 16'h0001, {15'h0000, r});
            plc.rd_word(8'h13, got);
            chk("stop word", {5'h00, stops, 5'h00}, got);
        end
        plc.wr_word(8'h40, r);
        chk("unmapped write", 16'h0000, {15'h0000, r});
        for (int i = 0; i < 12; i++) begin
            discharge(i[0], i % 3 != 2);
            // read the pair of the direction just used first
            for (int j = 0; j < 4; j++) begin
                plc.rd_word(tw[(j + 2 * i[0]) % 4], got);
                chk("track word", exp_trk[(j + 2 * i[0]) % 4], got);
            end
        end
        finish_test();
    end
endmodule : testbench
